/* File: design/sequence_condition_evaluator.sv */
`timescale 1ns/1ps
// What this block does
// - ON: true when the first operand bit is set.
// - OFF: true when the first operand bit is clear.
// - AND: true only when both operand bits are set.
// - OR: true when either operand bit is set.
// - data comparison of two signed two-word operands by selected operator.
// - timer true after programmed 10 ms ticks; level judgment is an error.
// - counter decrements per reference; zero gives false and reloads.
// - counter accepts level judgment only; edge is an error.
// - counter outside loop begin or loop end commands is an error.
// - external input only for start; true while high, edge waits rise.
// - host trigger starts waiting sequence; start only, edge only.
// - level judgment decides from the value at assessment.
// - edge judgment on an already true condition waits false then true, except timer and host trigger.
// - jump commands always use level judgment.
// - true skip at start: level skips, edge waits a new rise.
// - first operand is the left side, second the right side.
// - operand word is area first word plus offset; bit only for bits.
// - all comparison operands are signed 32-bit values.
module sequence_condition_evaluator #(
  parameter int TICK_CYCLES = seq_cond_pkg::TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        assess_req,
  input  wire logic        assess_cancel,
  input  wire logic [2:0]  cmd_kind,
  input  wire logic        ext_irq,
  input  wire logic        host_sequence_trigger,
  output logic             judge_done,
  output logic             judge_true,
  output logic             judge_busy,
  output logic             cfg_error
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EVAL  = 2'b10
  } state_t;

  operand_mem_if mif ();

  operand_ram u_ram (
    .clk  (clk),
    .port (mif.mem)
  );

  state_t                          state_r;
  logic [7:0]                      cond_cfg_r;
  logic [15:0]                     op1_r;
  logic [15:0]                     op2_r;
  logic [9:0]                      timer_set_r;
  logic [13:0]                     count_set_r;
  logic [31:0]                     const_r;
  logic [seq_cond_pkg::MEM_AW-1:0] maddr_r;
  logic [13:0]                     count_left_r;
  logic [9:0]                      timer_left_r;
  logic [31:0]                     tick_cnt_r;
  logic                            tick_en;
  logic [2:0]                      fetch_idx_r;
  logic [15:0]                     word_r [0:3];
  logic                            use_edge_r;
  logic                            armed_r;
  logic                            trig_seen_r;
  logic [31:0]                     reg_rdata_r;
  logic                            judge_done_r;
  logic                            judge_true_r;
  logic                            judge_busy_r;
  logic                            cfg_error_r;

  seq_cond_pkg::cond_t cond;
  seq_cond_pkg::cmp_t  cmp_op;
  logic        edge_sel;
  logic        start_ok;
  logic        cfg_bad;
  logic        cur;
  logic        done_now;
  logic        err_clr;
  logic signed [31:0] left_v;
  logic signed [31:0] right_v;
  logic        bit1;
  logic        bit2;

  assign cond     = seq_cond_pkg::cond_t'(
                      cond_cfg_r[seq_cond_pkg::COND_CODE_LSB +: 4]);
  assign cmp_op   = seq_cond_pkg::cmp_t'(
                      cond_cfg_r[seq_cond_pkg::COND_OP_LSB +: 3]);
  assign edge_sel = cond_cfg_r[seq_cond_pkg::COND_EDGE_BIT];
  assign start_ok = assess_req && !cfg_error_r && state_r == ST_IDLE;
  assign err_clr  = reg_wr && reg_addr == seq_cond_pkg::REG_STATUS
                    && reg_wdata[seq_cond_pkg::ST_ERR_BIT];

  function automatic logic [seq_cond_pkg::MEM_AW-1:0] word_addr(
    input logic [15:0] op,
    input logic        hi
  );
    logic [seq_cond_pkg::MEM_AW-1:0] base;
    base = seq_cond_pkg::MEM_AW'(op[seq_cond_pkg::OP_AREA_LSB +: 3])
           << seq_cond_pkg::AREA_SHIFT;
    return seq_cond_pkg::MEM_AW'(base
           + seq_cond_pkg::MEM_AW'(op[seq_cond_pkg::OP_OFF_LSB +: 8])
           + seq_cond_pkg::MEM_AW'(hi));
  endfunction

  // configuration checks made when a judgment is asked for
  always_comb
  begin
    cfg_bad = 1'b0;
    if (cond == seq_cond_pkg::C_TIMER && !edge_sel)
      cfg_bad = 1'b1;
    if (cond == seq_cond_pkg::C_COUNTER && edge_sel)
      cfg_bad = 1'b1;
    if (cond == seq_cond_pkg::C_COUNTER
        && cmd_kind != seq_cond_pkg::K_LOOP_BEGIN
        && cmd_kind != seq_cond_pkg::K_LOOP_END)
      cfg_bad = 1'b1;
    if ((cond == seq_cond_pkg::C_EXT_IRQ || cond == seq_cond_pkg::C_HOST_TRIG)
        && cmd_kind != seq_cond_pkg::K_START)
      cfg_bad = 1'b1;
    if (cond == seq_cond_pkg::C_HOST_TRIG && !edge_sel)
      cfg_bad = 1'b1;
    if (cond > seq_cond_pkg::C_HOST_TRIG)
      cfg_bad = 1'b1;
  end

  // operands: first is the left side, second the right side; lower word low
  always_comb
  begin
    if (op1_r[seq_cond_pkg::OP_AREA_LSB +: 4] == seq_cond_pkg::AREA_CONST)
    begin
      left_v = const_r;
      bit1   = const_r[op1_r[seq_cond_pkg::OP_BIT_LSB +: 4]];
    end
    else
    begin
      left_v = {word_r[1], word_r[0]};
      bit1   = word_r[0][op1_r[seq_cond_pkg::OP_BIT_LSB +: 4]];
    end
    if (op2_r[seq_cond_pkg::OP_AREA_LSB +: 4] == seq_cond_pkg::AREA_CONST)
    begin
      right_v = const_r;
      bit2    = const_r[op2_r[seq_cond_pkg::OP_BIT_LSB +: 4]];
    end
    else
    begin
      right_v = {word_r[3], word_r[2]};
      bit2    = word_r[2][op2_r[seq_cond_pkg::OP_BIT_LSB +: 4]];
    end
  end

  // present value of the selected condition
  always_comb
  begin
    cur = 1'b0;
    unique case (cond)
      seq_cond_pkg::C_ON:  cur = bit1;
      seq_cond_pkg::C_OFF: cur = !bit1;
      seq_cond_pkg::C_AND: cur = bit1 && bit2;
      seq_cond_pkg::C_OR:  cur = bit1 || bit2;
      seq_cond_pkg::C_DATA:
      begin
        unique case (cmp_op)
          seq_cond_pkg::OP_EQ: cur = left_v == right_v;
          seq_cond_pkg::OP_NE: cur = left_v != right_v;
          seq_cond_pkg::OP_LT: cur = left_v < right_v;
          seq_cond_pkg::OP_LE: cur = left_v <= right_v;
          seq_cond_pkg::OP_GT: cur = left_v > right_v;
          seq_cond_pkg::OP_GE: cur = left_v >= right_v;
          default:             cur = 1'b0;
        endcase
      end
      seq_cond_pkg::C_TIMER:     cur = timer_left_r == 10'h000;
      seq_cond_pkg::C_EXT_IRQ:   cur = ext_irq;
      seq_cond_pkg::C_HOST_TRIG: cur = trig_seen_r;
      default:     cur = 1'b0;
    endcase
  end

  // level reports at once; edge needs a false sample before a true one
  assign done_now = state_r == ST_EVAL
                    && (use_edge_r ? (cur && armed_r) : 1'b1);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r     <= ST_IDLE;
      fetch_idx_r <= 3'h0;
    end
    else if (assess_cancel)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (start_ok && !cfg_bad && cond != seq_cond_pkg::C_COUNTER)
          begin
            fetch_idx_r <= 3'h0;
            state_r     <= (cond <= seq_cond_pkg::C_DATA) ? ST_FETCH : ST_EVAL;
          end
        end
        ST_FETCH:
        begin
          fetch_idx_r <= fetch_idx_r + 3'h1;
          if (fetch_idx_r == 3'h4)
          begin
            state_r <= ST_EVAL;
          end
        end
        ST_EVAL:
        begin
          fetch_idx_r <= 3'h0;
          if (done_now)
          begin
            state_r <= ST_IDLE;
          end
          else if (cond <= seq_cond_pkg::C_DATA)
          begin
            // memory operands are sampled afresh on each edge retry
            state_r <= ST_FETCH;
          end
        end
      endcase
    end
  end

  assign mif.raddr = word_addr(fetch_idx_r[1] ? op2_r : op1_r,
                               fetch_idx_r[0]);
  assign mif.we    = reg_wr && reg_addr == seq_cond_pkg::REG_MDATA;
  assign mif.waddr = maddr_r;
  assign mif.wdata = reg_wdata[15:0];

  // capture read data one cycle after each address
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      word_r <= '{default: 16'h0000};
    end
    else if (state_r == ST_FETCH && fetch_idx_r != 3'h0)
    begin
      word_r[fetch_idx_r[1:0] - 2'h1] <= mif.rdata;
    end
  end

  // judgment mode and edge arming
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      use_edge_r <= 1'b0;
      armed_r    <= 1'b0;
    end
    else if (start_ok)
    begin
      use_edge_r <= edge_sel && cmd_kind != seq_cond_pkg::K_JUMP;
      // timer and trigger start false by nature, so they are armed now
      armed_r    <= cond == seq_cond_pkg::C_TIMER
                    || cond == seq_cond_pkg::C_HOST_TRIG;
    end
    else if (state_r == ST_EVAL && !cur)
    begin
      armed_r <= 1'b1;
    end
  end

  // host trigger caught between samples so a one-cycle pulse is not lost
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      trig_seen_r <= 1'b0;
    end
    else if (host_sequence_trigger)
    begin
      trig_seen_r <= 1'b1;
    end
    else if (start_ok)
    begin
      trig_seen_r <= 1'b0;
    end
  end

  // 10 ms tick divider
  always_ff @(posedge clk)
  begin
    if (rst || tick_en)
    begin
      tick_cnt_r <= 32'h00000000;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
    end
  end
  assign tick_en = tick_cnt_r == 32'(TICK_CYCLES - 1);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      timer_left_r <= seq_cond_pkg::TIMER_RST;
    end
    else if (start_ok && cond == seq_cond_pkg::C_TIMER)
    begin
      timer_left_r <= timer_set_r;
    end
    else if (state_r == ST_EVAL && tick_en && timer_left_r != 10'h000)
    begin
      // first tick may come early by up to one tick period
      timer_left_r <= timer_left_r - 10'h001;
    end
  end

  // countdown: each reference decrements; reaching zero reloads
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_left_r <= seq_cond_pkg::COUNT_RST;
    end
    else if (reg_wr && reg_addr == seq_cond_pkg::REG_COUNT)
    begin
      count_left_r <= reg_wdata[13:0];
    end
    else if (start_ok && !cfg_bad && cond == seq_cond_pkg::C_COUNTER)
    begin
      count_left_r <= (count_left_r <= 14'h0001) ? count_set_r
                      : count_left_r - 14'h0001;
    end
  end

  // answer to the sequence engine
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      judge_done_r <= 1'b0;
      judge_true_r <= 1'b0;
      judge_busy_r <= 1'b0;
    end
    else
    begin
      judge_done_r <= 1'b0;
      if (assess_cancel)
      begin
        judge_busy_r <= 1'b0;
      end
      else if (start_ok && !cfg_bad && cond == seq_cond_pkg::C_COUNTER)
      begin
        judge_done_r <= 1'b1;
        judge_true_r <= count_left_r > 14'h0001;
      end
      else if (start_ok && !cfg_bad)
      begin
        judge_busy_r <= 1'b1;
      end
      else if (done_now)
      begin
        judge_done_r <= 1'b1;
        judge_true_r <= cur;
        judge_busy_r <= 1'b0;
      end
    end
  end

  // error flag: set wins over a software clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg_error_r <= 1'b0;
    end
    else if (start_ok && cfg_bad)
    begin
      cfg_error_r <= 1'b1;
    end
    else if (err_clr)
    begin
      cfg_error_r <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cond_cfg_r  <= seq_cond_pkg::COND_RST;
      op1_r       <= seq_cond_pkg::OP_RST;
      op2_r       <= seq_cond_pkg::OP_RST;
      timer_set_r <= seq_cond_pkg::TIMER_RST;
      count_set_r <= seq_cond_pkg::COUNT_RST;
      const_r     <= seq_cond_pkg::CONST_RST;
      maddr_r     <= '0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        seq_cond_pkg::REG_COND:  cond_cfg_r  <= reg_wdata[7:0];
        seq_cond_pkg::REG_OP1:   op1_r       <= reg_wdata[15:0];
        seq_cond_pkg::REG_OP2:   op2_r       <= reg_wdata[15:0];
        seq_cond_pkg::REG_TIMER: timer_set_r <= reg_wdata[9:0];
        seq_cond_pkg::REG_COUNT: count_set_r <= reg_wdata[13:0];
        seq_cond_pkg::REG_CONST: const_r     <= reg_wdata;
        seq_cond_pkg::REG_MADDR: maddr_r     <= reg_wdata[10:0];
        seq_cond_pkg::REG_MDATA: maddr_r     <= maddr_r + 11'h001;
        default:                 maddr_r     <= maddr_r;
      endcase
    end
  end

  // read data; unmapped addresses and the memory window read zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reg_rdata_r <= 32'h00000000;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        seq_cond_pkg::REG_COND:   reg_rdata_r <= {24'h000000, cond_cfg_r};
        seq_cond_pkg::REG_OP1:    reg_rdata_r <= {16'h0000, op1_r};
        seq_cond_pkg::REG_OP2:    reg_rdata_r <= {16'h0000, op2_r};
        seq_cond_pkg::REG_TIMER:  reg_rdata_r <= {22'h000000, timer_set_r};
        seq_cond_pkg::REG_COUNT:  reg_rdata_r <= {18'h00000, count_set_r};
        seq_cond_pkg::REG_CONST:  reg_rdata_r <= const_r;
        seq_cond_pkg::REG_STATUS: reg_rdata_r <= {28'h0000000, armed_r,
                                   cfg_error_r, judge_true_r, judge_busy_r};
        seq_cond_pkg::REG_MADDR:  reg_rdata_r <= {21'h000000, maddr_r};
        seq_cond_pkg::REG_CLEFT:  reg_rdata_r <= {18'h00000, count_left_r};
        default:                  reg_rdata_r <= 32'h00000000;
      endcase
    end
    else
    begin
      reg_rdata_r <= 32'h00000000;
    end
  end

  assign reg_rdata  = reg_rdata_r;
  assign judge_done = judge_done_r;
  assign judge_true = judge_true_r;
  assign judge_busy = judge_busy_r;
  assign cfg_error  = cfg_error_r;

endmodule

/* File: shared/seq_cond_pkg.sv */
package seq_cond_pkg;

  // timing: one wait tick is 10 ms at a 8 ns clock
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_MS       = 10;
  localparam int TICK_CYC      = TICK_MS * 1000000 / CLK_PERIOD_NS;

  // operand memory: seven areas of 256 sixteen-bit words
  localparam int MEM_AW     = 11;
  localparam int MEM_WORDS  = 1792;
  localparam int AREA_SHIFT = 8;

  // register indices on the plain register port
  localparam logic [3:0] REG_COND   = 4'h0;
  localparam logic [3:0] REG_OP1    = 4'h1;
  localparam logic [3:0] REG_OP2    = 4'h2;
  localparam logic [3:0] REG_TIMER  = 4'h3;
  localparam logic [3:0] REG_COUNT  = 4'h4;
  localparam logic [3:0] REG_CONST  = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_MADDR  = 4'h7;
  localparam logic [3:0] REG_MDATA  = 4'h8;
  localparam logic [3:0] REG_CLEFT  = 4'h9;

  // field positions
  localparam int COND_CODE_LSB = 0;
  localparam int COND_EDGE_BIT = 4;
  localparam int COND_OP_LSB   = 5;
  localparam int OP_AREA_LSB   = 0;
  localparam int OP_OFF_LSB    = 4;
  localparam int OP_BIT_LSB    = 12;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_TRUE_BIT   = 1;
  localparam int ST_ERR_BIT    = 2;
  localparam int ST_ARMED_BIT  = 3;

  // reset values
  localparam logic [7:0]  COND_RST  = 8'h00;
  localparam logic [15:0] OP_RST    = 16'h0000;
  localparam logic [9:0]  TIMER_RST = 10'h000;
  localparam logic [13:0] COUNT_RST = 14'h0000;
  localparam logic [31:0] CONST_RST = 32'h00000000;

  localparam logic [3:0] AREA_CONST = 4'hF;

  typedef enum logic [3:0] {
    C_ON        = 4'b0000,
    C_OFF       = 4'b0001,
    C_AND       = 4'b0010,
    C_OR        = 4'b0011,
    C_DATA      = 4'b0100,
    C_TIMER     = 4'b0101,
    C_COUNTER   = 4'b0110,
    C_EXT_IRQ   = 4'b0111,
    C_HOST_TRIG = 4'b1000
  } cond_t;

  typedef enum logic [2:0] {
    K_START      = 3'b000,
    K_SKIP       = 3'b001,
    K_JUMP       = 3'b010,
    K_LOOP_BEGIN = 3'b011,
    K_LOOP_END   = 3'b100,
    K_OTHER      = 3'b101
  } cmd_t;

  typedef enum logic [2:0] {
    OP_EQ = 3'b000,
    OP_NE = 3'b001,
    OP_LT = 3'b010,
    OP_LE = 3'b011,
    OP_GT = 3'b100,
    OP_GE = 3'b101
  } cmp_t;

endpackage

/* File: shared/operand_mem_if.sv */
`timescale 1ns/1ps
interface operand_mem_if;
  logic                           we;
  logic [seq_cond_pkg::MEM_AW-1:0] waddr;
  logic [15:0]                    wdata;
  logic [seq_cond_pkg::MEM_AW-1:0] raddr;
  logic [15:0]                    rdata;

  modport ctl (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

/* File: design/operand_ram.sv */
`timescale 1ns/1ps
module operand_ram (
  input  wire logic   clk,
  operand_mem_if.mem  port
);

  logic [15:0] mem [0:seq_cond_pkg::MEM_WORDS-1];
  logic [15:0] rdata_r;

  always_ff @(posedge clk)
  begin
    if (port.we)
    begin
      mem[port.waddr] <= port.wdata;
    end
  end

  // read data one cycle after the address, from a register
  always_ff @(posedge clk)
  begin
    rdata_r <= mem[port.raddr];
  end

  assign port.rdata = rdata_r;

endmodule

/* File: verif/seq_cond_properties.sv */
`timescale 1ns/1ps
module seq_cond_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        assess_req,
  input wire logic        assess_cancel,
  input wire logic [2:0]  cmd_kind,
  input wire logic        ext_irq,
  input wire logic        host_sequence_trigger,
  input wire logic        judge_done,
  input wire logic        judge_true,
  input wire logic        judge_busy,
  input wire logic        cfg_error
);
  logic [7:0] cond_r;
  logic       go;
  logic [3:0] code;
  logic       edge_sel;
  logic       loop_cmd;
  assign go       = assess_req && !judge_busy && !cfg_error;
  assign code     = cond_r[3:0];
  assign edge_sel = cond_r[4];
  assign loop_cmd = cmd_kind == seq_cond_pkg::K_LOOP_BEGIN
                 || cmd_kind == seq_cond_pkg::K_LOOP_END;

  // mirror of the condition register, the checker sees only the ports
  always_ff @(posedge clk)
  begin
    if (rst)
      cond_r <= seq_cond_pkg::COND_RST;
    else if (reg_wr && reg_addr == seq_cond_pkg::REG_COND)
      cond_r <= reg_wdata[7:0];
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_done_idle: assert property (judge_done |-> !judge_busy)
    else $error("done while busy");
  chk_mem_latency: assert property (go && code <= seq_cond_pkg::C_DATA
    && (!edge_sel || cmd_kind == seq_cond_pkg::K_JUMP)
    |=> judge_busy [*6] ##1 (judge_done && !judge_busy))
    else $error("memory judgment latency wrong");
  chk_timer_level: assert property (go && code == seq_cond_pkg::C_TIMER
    && !edge_sel |=> cfg_error) else $error("timer level accepted");
  chk_count_edge: assert property (go && code == seq_cond_pkg::C_COUNTER
    && edge_sel |=> cfg_error) else $error("counter edge accepted");
  chk_count_cmd: assert property (go && code == seq_cond_pkg::C_COUNTER
    && !loop_cmd |=> cfg_error) else $error("counter outside loop accepted");
  chk_count_ref: assert property (go && code == seq_cond_pkg::C_COUNTER
    && !edge_sel && loop_cmd |=> judge_done) else $error("counter not answered");
  chk_trig_level: assert property (go && code == seq_cond_pkg::C_HOST_TRIG
    && !edge_sel |=> cfg_error) else $error("trigger level accepted");
  chk_irq_level: assert property (go && code == seq_cond_pkg::C_EXT_IRQ
    && !edge_sel && cmd_kind == seq_cond_pkg::K_START
    |=> ##1 (judge_done && judge_true == $past(ext_irq)))
    else $error("irq level wrong");
  chk_err_hold: assert property (cfg_error && !(reg_wr && reg_wdata[2]
    && reg_addr == seq_cond_pkg::REG_STATUS) |=> cfg_error)
    else $error("error flag dropped");
  chk_err_quiet: assert property (cfg_error |-> !judge_busy && !judge_done)
    else $error("judgment while in error");

  cover property (judge_done && judge_true);
  cover property (cfg_error);
  cover property (assess_cancel && judge_busy);
endmodule

/* File: verif/seq_host_model.sv */
`timescale 1ns/1ps
module seq_host_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic irq_level,
  input  wire logic trig_fire,
  output logic      ext_irq,
  output logic      host_sequence_trigger
);
  // the external input and the host trigger are both wired here, each registered once
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_irq               <= 1'b0;
      host_sequence_trigger <= 1'b0;
    end
    else
    begin
      ext_irq               <= irq_level;
      host_sequence_trigger <= trig_fire;
    end
  end
endmodule

/* File: verif/sequence_condition_evaluator_bench.sv */
`timescale 1ns/1ps
module sequence_condition_evaluator_bench;
  logic        clk = 0;
  logic        rst = 1;
  logic [3:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic [31:0] reg_rdata;
  logic        assess_req = 0;
  logic        assess_cancel = 0;
  logic [2:0]  cmd_kind = 0;
  logic        irq_level = 0;
  logic        trig_fire = 0;
  logic        ext_irq;
  logic        host_sequence_trigger;
  logic        judge_done;
  logic        judge_true;
  logic        judge_busy;
  logic        cfg_error;
  int          failures = 0;
  int          checks = 0;

  // short tick keeps the timer case to a few dozen cycles
  sequence_condition_evaluator #(.TICK_CYCLES(8)) u_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .assess_req(assess_req), .assess_cancel(assess_cancel),
    .cmd_kind(cmd_kind), .ext_irq(ext_irq),
    .host_sequence_trigger(host_sequence_trigger), .judge_done(judge_done),
    .judge_true(judge_true), .judge_busy(judge_busy), .cfg_error(cfg_error));

  seq_host_model u_host (
    .clk(clk), .rst(rst), .irq_level(irq_level), .trig_fire(trig_fire),
    .ext_irq(ext_irq), .host_sequence_trigger(host_sequence_trigger));

  initial
  begin
    forever #4 clk = ~clk;
  end

  task automatic test_done();
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask

  task automatic mem(input logic [10:0] a, input logic [15:0] d);
    wr(seq_cond_pkg::REG_MADDR, {21'h0, a});
    wr(seq_cond_pkg::REG_MDATA, {16'h0, d});
  endtask

  task automatic cond(input logic [3:0] c, input logic e, input logic [2:0] op);
    wr(seq_cond_pkg::REG_COND, {24'h0, op, e, c});
  endtask

  task automatic ask(input logic [2:0] c);
    @(posedge clk);
    assess_req <= 1'b1;
    cmd_kind   <= c;
    @(posedge clk);
    assess_req <= 1'b0;
    #1;
  endtask

  // a wait that runs out ends the run at once
  task automatic wdone(input logic e, input int lim, input string nm);
    int n;
    n = 0;
    while (judge_done !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (judge_done !== 1'b1)
    begin
      failures++;
      $display("[FAIL] %s exp done got none", nm);
      test_done();
    end
    else
      chk(nm, {31'h0, e}, {31'h0, judge_true});
  endtask

  task automatic judge(input logic [2:0] c, input logic e, input string nm);
    ask(c);
    wdone(e, 60, nm);
  endtask

  task automatic quiet(input int lim, input string nm);
    logic [31:0] seen;
    seen = 0;
    repeat (lim)
    begin
      @(posedge clk);
      #1;
      seen = seen | {31'h0, judge_done};
    end
    chk(nm, 32'h0, seen);
  endtask

  task automatic err(input logic [2:0] c, input string nm);
    ask(c);
    @(posedge clk);
    #1;
    chk(nm, 32'h1, {31'h0, cfg_error});
    wr(seq_cond_pkg::REG_STATUS, 32'h4);
    chk("error clear", 32'h0, {31'h0, cfg_error});
  endtask

  task automatic t_bits();
    logic [3:0] ex;
    ex = 4'b1001;
    mem(11'h103, 16'h0020); // area 1 starts at word 256
    mem(11'h200, 16'h0000);
    wr(seq_cond_pkg::REG_OP1, 32'h5031); // offset and bit in range
    wr(seq_cond_pkg::REG_OP2, 32'h5002);
    for (int i = 0; i < 4; i++)
    begin
      cond(i[3:0], 1'b0, 3'h0);
      judge(seq_cond_pkg::K_START, ex[i], "bit cond");
    end
  endtask

  task automatic t_data();
    logic [5:0] ex;
    ex = 6'b001110;
    mem(11'h00A, 16'hFFFE);
    mem(11'h00B, 16'hFFFF);
    wr(seq_cond_pkg::REG_OP1, 32'h00A0); // left side from memory
    wr(seq_cond_pkg::REG_OP2, 32'h000F); // constant on one side only
    wr(seq_cond_pkg::REG_CONST, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      cond(seq_cond_pkg::C_DATA, 1'b0, i[2:0]);
      judge(seq_cond_pkg::K_START, ex[i], "compare");
    end
  endtask

  task automatic t_count();
    logic [3:0] ex;
    ex = 4'b1011;
    wr(seq_cond_pkg::REG_COUNT, 32'h3); // count inside its range
    cond(seq_cond_pkg::C_COUNTER, 1'b0, 3'h0);
    for (int i = 0; i < 4; i++)
    begin
      ask(i[0] ? seq_cond_pkg::K_LOOP_END : seq_cond_pkg::K_LOOP_BEGIN);
      wdone(ex[i], 4, "count ref");
    end
    rd(seq_cond_pkg::REG_CLEFT, 32'h2, "count left");
    err(seq_cond_pkg::K_OTHER, "count cmd");
    cond(seq_cond_pkg::C_COUNTER, 1'b1, 3'h0);
    err(seq_cond_pkg::K_LOOP_BEGIN, "count edge");
    cond(4'hF, 1'b0, 3'h0);
    err(seq_cond_pkg::K_START, "bad code");
  endtask

  task automatic t_timer();
    wr(seq_cond_pkg::REG_TIMER, 32'h2); // wait inside its range
    cond(seq_cond_pkg::C_TIMER, 1'b1, 3'h0);
    judge(seq_cond_pkg::K_START, 1'b1, "timer");
    cond(seq_cond_pkg::C_TIMER, 1'b0, 3'h0);
    err(seq_cond_pkg::K_START, "timer level");
  endtask

  task automatic t_irq();
    irq_level <= 1'b1;
    cond(seq_cond_pkg::C_EXT_IRQ, 1'b0, 3'h0);
    judge(seq_cond_pkg::K_START, 1'b1, "irq level");
    err(seq_cond_pkg::K_SKIP, "irq not start");
    cond(seq_cond_pkg::C_EXT_IRQ, 1'b1, 3'h0);
    ask(seq_cond_pkg::K_START);
    quiet(20, "irq already high");
    assess_cancel <= 1'b1;
    @(posedge clk);
    assess_cancel <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("cancel idle", 32'h0, {31'h0, judge_busy});
    ask(seq_cond_pkg::K_START);
    irq_level <= 1'b0;
    repeat (4) @(posedge clk);
    irq_level <= 1'b1;
    wdone(1'b1, 10, "irq rise");
  endtask

  task automatic t_trig();
    cond(seq_cond_pkg::C_HOST_TRIG, 1'b1, 3'h0);
    ask(seq_cond_pkg::K_START);
    quiet(6, "trig wait");
    trig_fire <= 1'b1;
    @(posedge clk);
    trig_fire <= 1'b0;
    wdone(1'b1, 10, "trig start");
    cond(seq_cond_pkg::C_HOST_TRIG, 1'b0, 3'h0);
    err(seq_cond_pkg::K_START, "trig level");
  endtask

  task automatic t_jump();
    mem(11'h000, 16'h0001);
    wr(seq_cond_pkg::REG_OP1, 32'h0000);
    cond(seq_cond_pkg::C_ON, 1'b1, 3'h0);
    judge(seq_cond_pkg::K_JUMP, 1'b1, "jump level");
    ask(seq_cond_pkg::K_SKIP);
    quiet(20, "skip edge wait");
    mem(11'h000, 16'h0000);
    repeat (12) @(posedge clk);
    mem(11'h000, 16'h0001);
    wdone(1'b1, 40, "skip rise");
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(seq_cond_pkg::REG_STATUS, 32'h0, "status reset");
    rd(4'hF, 32'h0, "unmapped read");
    t_bits();
    t_data();
    t_count();
    t_timer();
    t_irq();
    t_trig();
    t_jump();
    test_done();
  end
endmodule

bind sequence_condition_evaluator seq_cond_properties u_props (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .assess_req(assess_req), .assess_cancel(assess_cancel),
  .cmd_kind(cmd_kind), .ext_irq(ext_irq),
  .host_sequence_trigger(host_sequence_trigger), .judge_done(judge_done),
  .judge_true(judge_true), .judge_busy(judge_busy), .cfg_error(cfg_error));
